// File: rcss_delay_if.sv
`timescale 1ns/10ps
interface rcss_delay_if;
    logic request;
    logic [13:0] delay_units;
    logic run_ok;
    logic pending;

    modport ctrl (output request, output delay_units, input run_ok, input pending);
    modport timer (input request, input delay_units, output run_ok, output pending);
endinterface

// File: rcss_partner.sv
`timescale 1ns/10ps
module rcss_partner (
    // clock
    input wire logic clk_in,
    // keypad keys {stop, rev, fwd} and terminal levels
    output logic [2:0] key_out,
    output logic [10:0] term_out,
    // serial host, field bus and plc run/reverse levels
    output logic [5:0] remote_out,
    // frame address seen by the link engine
    output logic frame_valid_out,
    output logic [7:0] frame_addr_out
);
    initial begin
        key_out = 3'h0;
        term_out = 11'h000;
        remote_out = 6'h00;
        frame_valid_out = 1'b0;
        frame_addr_out = 8'hFF;
    end

    // all levels change together just after an edge
    task drive(input logic [2:0] key, input logic [10:0] term, input logic [5:0] remote);
        @(posedge clk_in);
        key_out <= key;
        term_out <= term;
        remote_out <= remote;
    endtask

    // one-cycle address, then the released lines show its inverse
    task frame(input logic [7:0] addr);
        @(posedge clk_in);
        frame_valid_out <= 1'b1;
        frame_addr_out <= addr;
        @(posedge clk_in);
        frame_valid_out <= 1'b0;
        frame_addr_out <= ~addr;
    endtask
endmodule // rcss_partner

// File: rcss_pkg.sv
package rcss_pkg;

    // command source codes
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_TWO_TERM = 3'h1;
    localparam logic [2:0] SRC_RUN_DIR = 3'h2;
    localparam logic [2:0] SRC_SERIAL = 3'h3;
    localparam logic [2:0] SRC_FIELDBUS = 3'h4;
    localparam logic [2:0] SRC_PLC = 3'h5;
    localparam logic [2:0] SRC_MAX = 3'h5;
    localparam logic [2:0] SRC_RESET = 3'h1;

    // register byte offsets
    localparam logic [7:0] ADR_SOURCE = 8'h00;
    localparam logic [7:0] ADR_DELAY = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_STATION = 8'h0C;
    localparam logic [7:0] ADR_BAUD = 8'h10;
    localparam logic [7:0] ADR_FORMAT = 8'h14;
    localparam logic [7:0] ADR_PROTO = 8'h18;
    localparam logic [7:0] ADR_TERM_BASE = 8'h40;
    localparam logic [7:0] ADR_TERM_LAST = 8'h68;

    // multi-function terminals
    localparam int NUM_TERMS = 11;
    localparam logic [7:0] CODE_MAX = 8'h33;
    localparam logic [5:0] CODE_FWD = 6'h01;
    localparam logic [5:0] CODE_REV = 6'h02;
    localparam logic [5:0] CODE_NONE = 6'h00;

    // start delay, in units of 10 ms
    localparam logic [15:0] DELAY_MAX = 16'h2710;
    localparam logic [13:0] DELAY_RESET = 14'h0064;
    localparam int DELAY_UNIT_MS = 10;
    localparam int CLK_HZ = 100000000;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * (CLK_HZ / 1000);

    // serial link settings
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hFA;
    localparam logic [7:0] STATION_RESET = 8'h01;
    localparam logic [7:0] BAUD_MAX = 8'h05;
    localparam logic [2:0] BAUD_RESET = 3'h3;
    localparam logic [7:0] FORMAT_MAX = 8'h03;
    localparam logic [1:0] FORMAT_RESET = 2'h0;
    localparam logic [7:0] PROTO_MAX = 8'h01;
    localparam logic PROTO_RESET = 1'b0;

    // status word bit positions
    localparam int STAT_RUN = 0;
    localparam int STAT_REV = 1;
    localparam int STAT_PEND = 2;
    localparam int STAT_FWD_TERM = 3;
    localparam int STAT_REV_TERM = 4;
    localparam int STAT_SRC_LSB = 8;

endpackage

// File: rcss_start_delay.sv
`timescale 1ns/10ps
module rcss_start_delay #(
    parameter int UNIT_CYCLES = rcss_pkg::DELAY_UNIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    rcss_delay_if.timer dl
);
    localparam int PW = $clog2(UNIT_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYCLES - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} rcss_dly_e;

    rcss_dly_e state_r, state_nxt;
    logic [PW-1:0] pre_r, pre_nxt;
    logic [13:0] units_r, units_nxt;

    wire unit_done = (pre_r == PRE_LAST);
    wire [13:0] units_inc = units_r + 14'h0001;
    wire expire = unit_done && (units_inc >= dl.delay_units);

    always_comb begin
        state_nxt = state_r;
        pre_nxt = pre_r;
        units_nxt = units_r;
        case (state_r)
            ST_IDLE: begin
                pre_nxt = '0;
                units_nxt = 14'h0000;
                if (dl.request) begin
                    state_nxt = (dl.delay_units == 14'h0000) ? ST_RUN : ST_WAIT; // see (R6)
                end
            end
            ST_WAIT: begin
                if (!dl.request) begin
                    state_nxt = ST_IDLE; // see (R12)
                end else if (expire) begin
                    state_nxt = ST_RUN; // see (R6)
                end else if (unit_done) begin
                    pre_nxt = '0;
                    units_nxt = units_inc;
                end else begin
                    pre_nxt = pre_r + PW'(1);
                end
            end
            ST_RUN: begin
                if (!dl.request) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= ST_IDLE;
            pre_r <= '0;
            units_r <= 14'h0000;
        end else begin
            state_r <= state_nxt;
            pre_r <= pre_nxt;
            units_r <= units_nxt;
        end
    end

    assign dl.run_ok = (state_r == ST_RUN);
    assign dl.pending = (state_r == ST_WAIT);

    a_delay_cancel: assert property ( // see (R12)
        @(posedge clk_in) disable iff (!nrst_in)
        (state_r == ST_WAIT && !dl.request) |=> (state_r == ST_IDLE) ##1 !dl.run_ok)
        else $error("pending start not cancelled on withdrawal");

    a_delay_no_early: assert property ( // see (R6)
        @(posedge clk_in) disable iff (!nrst_in)
        (state_r == ST_IDLE && dl.request && dl.delay_units != 14'h0000)
        |=> (state_r == ST_WAIT && units_r == 14'h0000 && pre_r == '0))
        else $error("start delay skipped");

    c_delay_expire: cover property (
        @(posedge clk_in) disable iff (!nrst_in)
        (state_r == ST_WAIT) ##1 (state_r == ST_RUN));

endmodule // rcss_start_delay

// File: rcss_top.sv
`timescale 1ns/10ps
// Behaviour
// (R1) Source select 0..5 routes run commands: keypad, two schemes, serial, bus, PLC.
// (R2) Keypad source: forward key runs forward, reverse key reverse, stop key stops.
// (R3) Scheme one: function-1 terminal runs forward, function-2 terminal runs reverse.
// (R4) Scheme one: both terminals on or both off means stop.
// (R5) Scheme two: function-1 terminal enables run, function-2 terminal picks reverse.
// (R6) Terminal run starts after a settable delay 0.00-100.00 s, default 1.00 s.
// (R7) Eleven terminals each hold a function code 0..51.
// (R8) Serial source: run commands come from the host over the serial link.
// (R9) Station id 1..250, default 1; only frames for it are answered.
// (R10) Serial defaults: Modbus RTU, 9600 bps code, 8 data, no parity, 1 stop.
// (R11) Run commands from sources not selected are ignored.
// (R12) Withdrawing terminal run during the delay cancels the pending start.
module rcss_top #(
    parameter int DELAY_UNIT_CYCLES = rcss_pkg::DELAY_UNIT_CYCLES
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // keypad keys
    input wire logic KEY_FWD_IN,
    input wire logic KEY_REV_IN,
    input wire logic KEY_STOP_IN,
    // multi-function terminals
    input wire logic [10:0] TERM_IN,
    // serial, field bus and plc command levels
    input wire logic SER_RUN_IN,
    input wire logic SER_REV_IN,
    input wire logic FBUS_RUN_IN,
    input wire logic FBUS_REV_IN,
    input wire logic PLC_RUN_IN,
    input wire logic PLC_REV_IN,
    // serial frame address check
    input wire logic SER_FRAME_VALID_IN,
    input wire logic [7:0] SER_FRAME_ADDR_IN,
    output logic SER_ADDR_MATCH_OUT,
    // serial settings to the link engine
    output logic [7:0] SER_STATION_OUT,
    output logic [2:0] SER_BAUD_OUT,
    output logic [1:0] SER_FORMAT_OUT,
    output logic SER_PROTO_OUT,
    // drive command
    output logic RUN_OUT,
    output logic REVERSE_OUT,
    output logic START_PENDING_OUT
);
    localparam int NT = rcss_pkg::NUM_TERMS;

    logic ack_r;
    logic [31:0] rdata_r;
    logic [2:0] src_r;
    logic [13:0] delay_r;
    logic [7:0] station_r;
    logic [2:0] baud_r;
    logic [1:0] format_r;
    logic proto_r;
    logic [5:0] code_r [0:NT-1];
    logic kp_run_r, kp_run_nxt;
    logic kp_rev_r, kp_rev_nxt;
    logic run_r, rev_r, match_r;

    rcss_delay_if dl ();

    // bus decode
    wire wb_req = WB_CYC_IN && WB_STB_IN && !ack_r;
    wire wr_en = wb_req && WB_WE_IN;
    wire [7:0] wbyte = WB_DAT_IN[7:0];
    wire lane0 = WB_SEL_IN[0];
    wire hit_src = (WB_ADR_IN == rcss_pkg::ADR_SOURCE);
    wire hit_delay = (WB_ADR_IN == rcss_pkg::ADR_DELAY);
    wire hit_status = (WB_ADR_IN == rcss_pkg::ADR_STATUS);
    wire hit_station = (WB_ADR_IN == rcss_pkg::ADR_STATION);
    wire hit_baud = (WB_ADR_IN == rcss_pkg::ADR_BAUD);
    wire hit_format = (WB_ADR_IN == rcss_pkg::ADR_FORMAT);
    wire hit_proto = (WB_ADR_IN == rcss_pkg::ADR_PROTO);
    wire [7:0] term_off = WB_ADR_IN - rcss_pkg::ADR_TERM_BASE;
    wire [3:0] term_idx = term_off[5:2];
    wire hit_term = (WB_ADR_IN >= rcss_pkg::ADR_TERM_BASE)
        && (WB_ADR_IN <= rcss_pkg::ADR_TERM_LAST) && (WB_ADR_IN[1:0] == 2'h0);

    // out-of-range values leave the setting unchanged
    wire src_we = wr_en && hit_src && lane0 && (wbyte <= {5'h00, rcss_pkg::SRC_MAX});
    wire delay_we = wr_en && hit_delay && (WB_SEL_IN[1:0] == 2'h3)
        && (WB_DAT_IN[15:0] <= rcss_pkg::DELAY_MAX);
    wire station_we = wr_en && hit_station && lane0
        && (wbyte >= rcss_pkg::STATION_MIN) && (wbyte <= rcss_pkg::STATION_MAX);
    wire baud_we = wr_en && hit_baud && lane0 && (wbyte <= rcss_pkg::BAUD_MAX);
    wire format_we = wr_en && hit_format && lane0 && (wbyte <= rcss_pkg::FORMAT_MAX);
    wire proto_we = wr_en && hit_proto && lane0 && (wbyte <= rcss_pkg::PROTO_MAX);
    wire code_ok = wr_en && hit_term && lane0 && (wbyte <= rcss_pkg::CODE_MAX);

    // terminal function decode
    logic [NT-1:0] fwd_hit;
    logic [NT-1:0] rev_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_term
            localparam logic [5:0] CODE_RST = (gi == 0) ? rcss_pkg::CODE_FWD :
                (gi == 1) ? rcss_pkg::CODE_REV : rcss_pkg::CODE_NONE;
            always_ff @(posedge CLK_IN or negedge NRST_IN) begin
                if (!NRST_IN) begin
                    code_r[gi] <= CODE_RST;
                end else if (code_ok && term_idx == 4'(gi)) begin
                    code_r[gi] <= wbyte[5:0]; // see (R7)
                end
            end
            assign fwd_hit[gi] = TERM_IN[gi] && (code_r[gi] == rcss_pkg::CODE_FWD); // see (R3)
            assign rev_hit[gi] = TERM_IN[gi] && (code_r[gi] == rcss_pkg::CODE_REV); // see (R3)
        end
    endgenerate

    wire fwd_term = |fwd_hit;
    wire rev_term = |rev_hit;
    wire is_kp = (src_r == rcss_pkg::SRC_KEYPAD);
    wire is_two = (src_r == rcss_pkg::SRC_TWO_TERM);
    wire is_rdir = (src_r == rcss_pkg::SRC_RUN_DIR);

    // terminal run request; equal levels in scheme one mean stop
    wire term_req = is_two ? (fwd_term ^ rev_term) : (is_rdir && fwd_term); // see (R4) (R5)
    wire term_run = term_req && dl.run_ok; // see (R6)

    assign dl.request = term_req;
    assign dl.delay_units = delay_r;

    rcss_start_delay #(
        .UNIT_CYCLES(DELAY_UNIT_CYCLES)
    ) u_delay (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .dl(dl)
    );

    // keypad latch, stop key has priority
    always_comb begin
        kp_run_nxt = kp_run_r;
        kp_rev_nxt = kp_rev_r;
        if (!is_kp) begin
            kp_run_nxt = 1'b0; // see (R11)
        end else if (KEY_STOP_IN) begin
            kp_run_nxt = 1'b0; // see (R2)
        end else if (KEY_FWD_IN) begin
            kp_run_nxt = 1'b1; // see (R2)
            kp_rev_nxt = 1'b0;
        end else if (KEY_REV_IN) begin
            kp_run_nxt = 1'b1; // see (R2)
            kp_rev_nxt = 1'b1;
        end
    end

    // source selection
    wire sel_run = is_kp ? kp_run_r :
        (is_two || is_rdir) ? term_run :
        (src_r == rcss_pkg::SRC_SERIAL) ? SER_RUN_IN :
        (src_r == rcss_pkg::SRC_FIELDBUS) ? FBUS_RUN_IN :
        (src_r == rcss_pkg::SRC_PLC) ? PLC_RUN_IN : 1'b0; // see (R1) (R8) (R11)
    wire sel_rev = is_kp ? kp_rev_r :
        (is_two || is_rdir) ? rev_term :
        (src_r == rcss_pkg::SRC_SERIAL) ? SER_REV_IN :
        (src_r == rcss_pkg::SRC_FIELDBUS) ? FBUS_REV_IN :
        (src_r == rcss_pkg::SRC_PLC) ? PLC_REV_IN : 1'b0; // see (R1) (R5) (R11)

    wire frame_match = SER_FRAME_VALID_IN && (SER_FRAME_ADDR_IN == station_r); // see (R9)

    // read mux
    wire [31:0] status_word = (32'(src_r) << rcss_pkg::STAT_SRC_LSB)
        | (32'(rev_term) << rcss_pkg::STAT_REV_TERM)
        | (32'(fwd_term) << rcss_pkg::STAT_FWD_TERM)
        | (32'(dl.pending) << rcss_pkg::STAT_PEND)
        | (32'(rev_r) << rcss_pkg::STAT_REV)
        | (32'(run_r) << rcss_pkg::STAT_RUN);
    wire [31:0] rd_data = hit_src ? 32'(src_r) :
        hit_delay ? 32'(delay_r) :
        hit_status ? status_word :
        hit_station ? 32'(station_r) :
        hit_baud ? 32'(baud_r) :
        hit_format ? 32'(format_r) :
        hit_proto ? 32'(proto_r) :
        hit_term ? 32'(code_r[term_idx]) : 32'h0000_0000;

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_req;
            rdata_r <= (wb_req && !WB_WE_IN) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            src_r <= rcss_pkg::SRC_RESET;
            delay_r <= rcss_pkg::DELAY_RESET;
        end else begin
            if (src_we) src_r <= wbyte[2:0]; // see (R1)
            if (delay_we) delay_r <= WB_DAT_IN[13:0]; // see (R6)
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            station_r <= rcss_pkg::STATION_RESET;
            baud_r <= rcss_pkg::BAUD_RESET;
            format_r <= rcss_pkg::FORMAT_RESET;
            proto_r <= rcss_pkg::PROTO_RESET;
        end else begin
            if (station_we) station_r <= wbyte; // see (R9)
            if (baud_we) baud_r <= wbyte[2:0]; // see (R10)
            if (format_we) format_r <= wbyte[1:0]; // see (R10)
            if (proto_we) proto_r <= wbyte[0]; // see (R10)
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            kp_run_r <= 1'b0;
            kp_rev_r <= 1'b0;
            run_r <= 1'b0;
            rev_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            kp_run_r <= kp_run_nxt;
            kp_rev_r <= kp_rev_nxt;
            run_r <= sel_run;
            rev_r <= sel_rev;
            match_r <= frame_match;
        end
    end

    assign WB_ACK_OUT = ack_r;
    assign WB_DAT_OUT = rdata_r;
    assign RUN_OUT = run_r;
    assign REVERSE_OUT = rev_r;
    assign START_PENDING_OUT = dl.pending;
    assign SER_ADDR_MATCH_OUT = match_r;
    assign SER_STATION_OUT = station_r;
    assign SER_BAUD_OUT = baud_r;
    assign SER_FORMAT_OUT = format_r;
    assign SER_PROTO_OUT = proto_r;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_keypad_stop_wins: assert property ( // see (R2)
        (is_kp && KEY_STOP_IN) ##1 is_kp |=> !RUN_OUT)
        else $error("stop key did not stop the drive");

    a_keypad_forward: assert property ( // see (R2)
        (is_kp && KEY_FWD_IN && !KEY_STOP_IN) ##1 is_kp |=> (RUN_OUT && !REVERSE_OUT))
        else $error("forward key did not run forward");

    a_keypad_reverse: assert property ( // see (R2)
        (is_kp && KEY_REV_IN && !KEY_FWD_IN && !KEY_STOP_IN) ##1 is_kp
        |=> (RUN_OUT && REVERSE_OUT))
        else $error("reverse key did not run reverse");

    a_two_term_stop: assert property ( // see (R4)
        (is_two && fwd_term == rev_term) |=> !RUN_OUT)
        else $error("equal terminal levels did not stop");

    a_two_term_dir: assert property ( // see (R3)
        (is_two && dl.run_ok && (fwd_term != rev_term))
        |=> (RUN_OUT && REVERSE_OUT == $past(rev_term)))
        else $error("scheme one direction wrong");

    a_run_dir_dir: assert property ( // see (R5)
        is_rdir |=> (REVERSE_OUT == $past(rev_term) && RUN_OUT == $past(fwd_term && dl.run_ok)))
        else $error("scheme two run or direction wrong");

    a_start_delay_hold: assert property ( // see (R6)
        ($rose(term_req) && delay_r != 14'h0000) |=> !RUN_OUT [*3])
        else $error("terminal run began before the delay");

    a_serial_follow: assert property ( // see (R8)
        (src_r == rcss_pkg::SRC_SERIAL) |=> (RUN_OUT == $past(SER_RUN_IN)
        && REVERSE_OUT == $past(SER_REV_IN)))
        else $error("serial command not followed");

    a_other_ignored: assert property ( // see (R11)
        (is_kp && !kp_run_r) |=> !RUN_OUT)
        else $error("unselected source drove the run output");

    a_station_match: assert property ( // see (R9)
        SER_FRAME_VALID_IN |=> (SER_ADDR_MATCH_OUT
        == ($past(SER_FRAME_ADDR_IN) == $past(SER_STATION_OUT))))
        else $error("station address check wrong");

    a_bad_write_kept: assert property ( // see (R1)
        (wr_en && lane0 && hit_src && wbyte > 8'h05) |=> $stable(src_r))
        else $error("out-of-range source accepted");

    a_wb_ack_pulse: assert property (
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held longer than one cycle");

    c_keypad_run: cover property (is_kp && RUN_OUT ##1 KEY_STOP_IN);
    c_term_start: cover property (is_two && dl.pending ##2 RUN_OUT);
    c_serial_run: cover property ((src_r == rcss_pkg::SRC_SERIAL) && RUN_OUT);
    c_frame_match: cover property (SER_ADDR_MATCH_OUT);

endmodule // rcss_top

// File: tb.sv
`timescale 1ns/10ps
module tb;
    typedef struct {logic we; logic [7:0] adr; logic [31:0] wd; logic [31:0] exp;} rcss_reg_s;
    typedef struct {logic [2:0] src; logic [10:0] term; logic [5:0] rem; logic [1:0] exp;} rcss_cmd_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [2:0] key;
    logic [10:0] term;
    logic [5:0] remote;
    logic fvalid;
    logic [7:0] faddr;
    logic match;
    logic [7:0] station;
    logic [2:0] baud;
    logic [1:0] fmt;
    logic proto;
    logic run;
    logic rev;
    logic pend;
    logic [31:0] rd;
    int fail_count = 0;
    int check_count = 0;
    rcss_reg_s regs [23] = '{
        '{0, 8'h00, 0, 32'h1}, '{0, 8'h04, 0, 32'h64}, '{0, 8'h0C, 0, 32'h1},
        '{0, 8'h10, 0, 32'h3}, '{0, 8'h14, 0, 32'h0}, '{0, 8'h18, 0, 32'h0},
        '{0, 8'h40, 0, 32'h1}, '{0, 8'h44, 0, 32'h2}, '{0, 8'h48, 0, 32'h0},
        '{1, 8'h00, 32'h5, 32'h5}, '{1, 8'h00, 32'h6, 32'h5},
        '{1, 8'h04, 32'h2710, 32'h2710}, '{1, 8'h04, 32'h2711, 32'h2710},
        '{1, 8'h0C, 32'hFA, 32'hFA}, '{1, 8'h0C, 32'hFB, 32'hFA}, '{1, 8'h0C, 32'h0, 32'hFA},
        '{1, 8'h10, 32'h5, 32'h5}, '{1, 8'h10, 32'h6, 32'h5}, '{1, 8'h14, 32'h3, 32'h3},
        '{1, 8'h18, 32'h1, 32'h1}, '{1, 8'h68, 32'h33, 32'h33}, '{1, 8'h68, 32'h34, 32'h33},
        '{1, 8'h30, 32'h7, 32'h0}};
    rcss_cmd_s cmds [15] = '{
        '{1, 11'h001, 6'h00, 2'b10}, '{1, 11'h002, 6'h00, 2'b11}, '{1, 11'h003, 6'h00, 2'b01},
        '{1, 11'h000, 6'h3F, 2'b00}, '{1, 11'h080, 6'h00, 2'b10}, '{2, 11'h001, 6'h00, 2'b10},
        '{2, 11'h003, 6'h00, 2'b11}, '{2, 11'h002, 6'h00, 2'b01}, '{3, 11'h000, 6'h03, 2'b11},
        '{3, 11'h001, 6'h3C, 2'b00}, '{4, 11'h000, 6'h04, 2'b10}, '{4, 11'h000, 6'h33, 2'b00},
        '{5, 11'h000, 6'h30, 2'b11}, '{5, 11'h001, 6'h0F, 2'b00}, '{1, 11'h000, 6'h00, 2'b00}};

    always #5 clk = ~clk;

    rcss_partner i_partner (.clk_in(clk), .key_out(key), .term_out(term), .remote_out(remote),
        .frame_valid_out(fvalid), .frame_addr_out(faddr));

    rcss_top #(.DELAY_UNIT_CYCLES(4)) i_dut (
        .CLK_IN(clk), .NRST_IN(nrst),
        .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb), .WB_WE_IN(wb_we), .WB_ADR_IN(wb_adr),
        .WB_SEL_IN(wb_sel), .WB_DAT_IN(wb_dat), .WB_DAT_OUT(wb_rdat), .WB_ACK_OUT(wb_ack),
        .KEY_FWD_IN(key[0]), .KEY_REV_IN(key[1]), .KEY_STOP_IN(key[2]), .TERM_IN(term),
        .SER_RUN_IN(remote[0]), .SER_REV_IN(remote[1]), .FBUS_RUN_IN(remote[2]),
        .FBUS_REV_IN(remote[3]), .PLC_RUN_IN(remote[4]), .PLC_REV_IN(remote[5]),
        .SER_FRAME_VALID_IN(fvalid), .SER_FRAME_ADDR_IN(faddr), .SER_ADDR_MATCH_OUT(match),
        .SER_STATION_OUT(station), .SER_BAUD_OUT(baud), .SER_FORMAT_OUT(fmt),
        .SER_PROTO_OUT(proto), .RUN_OUT(run), .REVERSE_OUT(rev), .START_PENDING_OUT(pend));

    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // classic single cycle, held until ack is sampled high
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_dat <= wd;
        n = 0;
        @(posedge clk);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20)
            chk("bus ack", 32'h0, 32'h1);
    endtask

    task look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        look(1);
        chk("reset outputs", 32'({station, baud, fmt, proto, run, rev, pend, match}), 32'h0580);
        foreach (regs[i]) begin
            if (regs[i].we)
                wb(1'b1, regs[i].adr, regs[i].wd);
            wb(1'b0, regs[i].adr, 32'h0);
            chk("register", rd, regs[i].exp);
        end
        look(1);
        chk("serial settings", 32'({station, baud, fmt, proto}), 32'({8'hFA, 3'h5, 2'h3, 1'b1}));
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h5C, 32'h1);
        foreach (cmds[i]) begin
            wb(1'b1, 8'h00, 32'(cmds[i].src));
            i_partner.drive(3'h0, cmds[i].term, cmds[i].rem);
            look(4);
            chk("run and direction", 32'({run, rev}), 32'(cmds[i].exp));
        end
        // keypad latches; other sources are active during the forward check to show they are ignored
        wb(1'b1, 8'h00, 32'h0);
        i_partner.drive(3'h1, 11'h001, 6'h3F);
        i_partner.drive(3'h0, 11'h001, 6'h3F);
        look(3);
        chk("keypad forward", 32'({run, rev}), 32'h2);
        i_partner.drive(3'h2, 11'h000, 6'h00);
        i_partner.drive(3'h0, 11'h000, 6'h00);
        look(3);
        chk("keypad reverse", 32'({run, rev}), 32'h3);
        i_partner.drive(3'h7, 11'h000, 6'h00);
        i_partner.drive(3'h0, 11'h000, 6'h00);
        look(3);
        chk("keypad stop", 32'(run), 32'h0);
        // start delay of 3 units of 4 cycles
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h04, 32'h3);
        i_partner.drive(3'h0, 11'h001, 6'h00);
        look(2);
        chk("delay pending", 32'({run, pend}), 32'h1);
        look(6);
        chk("delay still waiting", 32'(run), 32'h0);
        look(12);
        chk("delay expired", 32'({run, pend}), 32'h2);
        wb(1'b0, 8'h08, 32'h0);
        chk("status word", rd, 32'h109);
        i_partner.drive(3'h0, 11'h000, 6'h00);
        look(3);
        i_partner.drive(3'h0, 11'h001, 6'h00);
        look(3);
        i_partner.drive(3'h0, 11'h000, 6'h00);
        look(2);
        chk("withdrawn start", 32'({run, pend}), 32'h0);
        i_partner.drive(3'h0, 11'h001, 6'h00);
        look(12);
        chk("count restarted", 32'(run), 32'h0);
        look(8);
        chk("restarted run", 32'(run), 32'h1);
        // station address match
        i_partner.frame(8'hFA);
        #1;
        chk("own frame", 32'(match), 32'h1);
        look(1);
        chk("match one cycle", 32'(match), 32'h0);
        i_partner.frame(8'hFB);
        #1;
        chk("foreign frame", 32'(match), 32'h0);
        // second reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        look(2);
        chk("reset mid-run", 32'({station, baud, run}), 32'h016);
        @(posedge clk);
        nrst <= 1'b1;
        look(1);
        wb(1'b0, 8'h0C, 32'h0);
        chk("station after reset", rd, 32'h1);
        report_and_stop();
    end
endmodule // tb
